// [core/aqs_pkg.sv]
package aqs_pkg;

  // Clock and derived rates
  localparam int CLK_PERIOD_NS = 10;
  localparam int MAIN_HZ = 8_000_000;
  localparam int AUX_HZ = 32_768;
  localparam int MAIN_DIV = 1_000_000_000 / (CLK_PERIOD_NS * MAIN_HZ);
  localparam int AUX_DIV = 1_000_000_000 / (CLK_PERIOD_NS * AUX_HZ);

  // Long periods, counted in auxiliary ticks or system ticks
  localparam int WDOG_TIMEOUT_S = 3;
  localparam int TICK_S = 1;
  localparam int FAN_RAMP_S = 3;
  localparam int PM_PERIOD_MIN = 30;
  localparam int HUM_PERIOD_S = 30;
  localparam int PM_TICKS = PM_PERIOD_MIN * 60 / TICK_S;
  localparam int HUM_TICKS = HUM_PERIOD_S / TICK_S;

  // Sensor pulse timing, counted in main-rate enables
  localparam int SAMP_PERIOD_MS = 10;
  localparam int PULSE_W_US = 320;
  localparam int ADC_AT_US = 280;
  localparam int PULSE_W_CYC = PULSE_W_US * (MAIN_HZ / 1_000_000);
  localparam int ADC_AT_CYC = ADC_AT_US * (MAIN_HZ / 1_000_000);
  localparam int SAMP_PER_CYC = SAMP_PERIOD_MS * (MAIN_HZ / 1000);

  // Averaging: mean of 50 samples by reciprocal multiply
  localparam int PM_SAMPLES = 50;
  localparam int ADC_W = 12;
  localparam int ACC_W = 18;
  localparam logic [15:0] RECIP_50 = 16'h051f;
  localparam int RECIP_SH = 16;
  localparam logic [7:0] HUM_SCALE = 8'h64;
  localparam logic [7:0] TEMP_SCALE = 8'ha5;
  localparam logic [7:0] TEMP_OFS = 8'h28;
  localparam logic [13:0] DISP_MAX = 14'h270f;

  // Register offsets and control fields
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_PM = 4'h8;
  localparam logic [3:0] REG_HT = 4'hc;
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_HEAT_BIT = 2;
  localparam int CTRL_TRES_BIT = 3;
  localparam int CTRL_HRES_LSB = 4;
  localparam int CTRL_RUN_BIT = 6;
  localparam logic [6:0] CTRL_RST = 7'h43;

  typedef enum logic [1:0] {
    MODE_TEMP = 2'h0, MODE_HUM = 2'h1, MODE_PM = 2'h2, MODE_AQI = 2'h3
  } aqs_mode_e;

  // Gray codes along sleep, wake, ref, ramp, sample, fan off, calc, show
  typedef enum logic [2:0] {
    ST_SLEEP = 3'h0, ST_WAKE = 3'h1, ST_REF = 3'h3, ST_RAMP = 3'h2,
    ST_SAMP = 3'h6, ST_FANOFF = 3'h7, ST_CALC = 3'h5, ST_SHOW = 3'h4
  } aqs_state_e;

  typedef struct packed {
    logic heater;
    logic tres;
    logic [1:0] hres;
  } aqs_hum_cfg_s;

  typedef struct packed {
    logic upd;
    logic [3:0] mask;
    logic [31:0] chars;
  } aqs_disp_s;

  // Banners, four ASCII characters, unused places masked off
  localparam logic [31:0] BAN_CAL = 32'h43414c00;
  localparam logic [31:0] BAN_LOW = 32'h4c4f5700;
  localparam logic [31:0] BAN_HIGH = 32'h48494748;
  localparam logic [3:0] MASK_3 = 4'he;
  localparam logic [3:0] MASK_4 = 4'hf;

  // Glyph set the display can draw: A-Z, 0-9 and percent
  function automatic logic aqs_glyph_ok(input logic [7:0] c);
    aqs_glyph_ok = (c >= 8'h41 && c <= 8'h5a) ||
                   (c >= 8'h30 && c <= 8'h39) || (c == 8'h25);
  endfunction

endpackage

// [core/aqs_rate_div.sv]
`timescale 1ns/1ps
module aqs_rate_div
  import aqs_pkg::*;
#(
  parameter int DIV = MAIN_DIV
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  output logic en_o
);

  localparam int CW = $clog2(DIV);

  if (DIV < 2) begin : g_chk
    $error("aqs_rate_div needs DIV of at least 2");
  end

  // Free-running count
  logic [CW-1:0] cnt_q;

  // Count up to the divider and pulse once per wrap
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_q <= '0;
      en_o <= 1'b0;
    end else begin
      en_o <= (cnt_q == CW'(DIV - 1));
      cnt_q <= (cnt_q == CW'(DIV - 1)) ? '0 : cnt_q + 1'b1;
    end
  end

endmodule

// [core/aqs_digits.sv]
`timescale 1ns/1ps
module aqs_digits
  import aqs_pkg::*;
(
  input wire logic [13:0] val_i,
  output logic [31:0] chars_o
);

  // Decimal digits packed four bits each
  logic [15:0] bcd;

  // Shift-and-add-three conversion to four decimal places
  always_comb begin
    bcd = '0;
    for (int i = 13; i >= 0; i--) begin
      for (int d = 0; d < 4; d++) begin
        if (bcd[d*4 +: 4] > 4'h4) begin
          bcd[d*4 +: 4] = bcd[d*4 +: 4] + 4'h3;
        end
      end
      bcd = {bcd[14:0], val_i[i]};
    end
  end

  // Each digit becomes its ASCII code
  for (genvar g = 0; g < 4; g++) begin : g_chr
    assign chars_o[g*8 +: 8] = {4'h3, bcd[g*4 +: 4]};
  end

endmodule

// [core/aqs_sequencer.sv]
`timescale 1ns/1ps
module aqs_sequencer
  import aqs_pkg::*;
#(
  parameter int WDOG_AUX = WDOG_TIMEOUT_S * AUX_HZ,
  parameter int TICK_AUX = TICK_S * AUX_HZ,
  parameter int RAMP_AUX = FAN_RAMP_S * AUX_HZ,
  parameter int SAMP_PER = SAMP_PER_CYC,
  parameter int AUX_DIVIDE = AUX_DIV,
  parameter logic [ADC_W-1:0] LOW_THR = 12'h010,
  parameter logic [ADC_W-1:0] HIGH_THR = 12'hf00
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic we_i,
  input wire logic re_i,
  output logic [31:0] rdata_o,
  input wire logic adc_done_i,
  input wire logic [ADC_W-1:0] adc_data_i,
  input wire logic hum_ready_i,
  input wire logic i2c_done_i,
  input wire logic i2c_ok_i,
  input wire logic [31:0] i2c_data_i,
  output logic fan_o,
  output logic sensor_pulse_o,
  output logic adc_start_o,
  output logic hum_start_o,
  output logic i2c_start_o,
  output aqs_hum_cfg_s hum_cfg_o,
  output aqs_disp_s disp_o,
  output logic lowpower_o,
  output logic wdog_bite_o
);

  localparam int WW = $clog2(WDOG_AUX + 1);
  localparam int TW = $clog2(TICK_AUX + 1);
  localparam int RW = $clog2(RAMP_AUX + 1);
  localparam int PW = $clog2(SAMP_PER + 1);
  localparam int PMW = $clog2(PM_TICKS + 1);
  localparam int HW = $clog2(HUM_TICKS + 1);

  if (SAMP_PER <= PULSE_W_CYC || WDOG_AUX <= TICK_AUX) begin : g_chk
    $error("aqs_sequencer: sample period or watchdog too short");
  end

  // Rate enables and shown value
  logic main_en;                      // 8 MHz step
  logic aux_en;                       // 32 kHz step
  logic [31:0] dig_chars;             // Decimal text of shown value
  logic [13:0] show_val;              // Value handed to the converter

  // Control and status
  logic [6:0] ctrl_q;                 // Software control word
  aqs_state_e st_q;                   // Sequencer state
  logic [TW-1:0] tick_cnt_q;          // Tick period count
  logic tick_q;                       // System tick pulse
  logic [WW-1:0] wdog_cnt_q;          // Watchdog count
  logic [PMW-1:0] pm_cnt_q;           // Ticks since last particulate run
  logic [HW-1:0] hum_cnt_q;           // Ticks since last humidity run
  logic [RW-1:0] ramp_cnt_q;          // Fan ramp count
  logic [PW-1:0] ph_q;                // Position inside one sample period
  logic [5:0] n_q;                    // Samples taken
  logic ref_got_q;                    // Reference sample stored
  logic [ADC_W-1:0] ref_q;            // Clean-air reference
  logic [ACC_W-1:0] acc_q;            // Sample sum
  logic [ADC_W-1:0] pm_q;             // Particulate result
  logic pm_low_q;                     // Result below lower threshold
  logic pm_high_q;                    // Result above upper threshold
  logic hum_pend_q;                   // Humidity result awaited
  logic i2c_busy_q;                   // Result read in flight
  logic hum_new_q;                    // Fresh humidity result
  logic [31:0] ht_q;                  // Temperature and humidity raw

  // Derived values
  aqs_mode_e mode;
  logic run;
  logic pm_mode;
  logic sampling;
  logic ph_wrap;
  logic [ACC_W+15:0] mean_prod;
  logic [ADC_W-1:0] mean;
  logic [23:0] hum_prod;
  logic [23:0] temp_prod;

  assign mode = aqs_mode_e'(ctrl_q[CTRL_MODE_LSB +: 2]);
  assign run = ctrl_q[CTRL_RUN_BIT];
  assign pm_mode = (mode == MODE_PM) || (mode == MODE_AQI);
  assign sampling = (st_q == ST_REF) || (st_q == ST_SAMP);
  assign ph_wrap = main_en && (ph_q == PW'(SAMP_PER - 1));
  assign mean_prod = acc_q * RECIP_50;
  assign mean = mean_prod[RECIP_SH +: ADC_W];
  assign hum_prod = ht_q[15:0] * HUM_SCALE;
  assign temp_prod = ht_q[31:16] * TEMP_SCALE;

  // Rate dividers for the main and auxiliary clocks
  aqs_rate_div #(.DIV(MAIN_DIV)) u_main_div (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .en_o(main_en)
  );

  aqs_rate_div #(.DIV(AUX_DIVIDE)) u_aux_div (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .en_o(aux_en)
  );

  aqs_digits u_digits (
    .val_i(show_val),
    .chars_o(dig_chars)
  );

  // Pick the value to show, clamped to four digits
  always_comb begin
    show_val = '0;
    if (pm_mode) begin
      show_val = 14'(pm_q);
    end else if (mode == MODE_HUM) begin
      show_val = 14'(hum_prod[23:16]);
    end else if (temp_prod[23:16] > TEMP_OFS) begin
      show_val = 14'(temp_prod[23:16] - TEMP_OFS);
    end
    if (show_val > DISP_MAX) begin
      show_val = DISP_MAX;
    end
  end

  // Register writes
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl_q <= CTRL_RST;
    end else if (we_i && addr_i == REG_CTRL) begin
      ctrl_q <= wdata_i[6:0];
    end
  end

  // Register reads, answer one cycle later, unmapped reads zero
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_o <= '0;
    end else if (re_i) begin
      case (addr_i)
        REG_CTRL: rdata_o <= {25'h0, ctrl_q};
        REG_STATUS: rdata_o <= {24'h0, lowpower_o, i2c_busy_q,
                                hum_pend_q, fan_o, 1'b0, st_q};
        REG_PM: rdata_o <= {18'h0, pm_high_q, pm_low_q, pm_q};
        REG_HT: rdata_o <= ht_q;
        default: rdata_o <= '0;
      endcase
    end else begin
      rdata_o <= '0;
    end
  end

  // Humidity sensor setup from the control word
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hum_cfg_o <= '0;
    end else begin
      hum_cfg_o.heater <= ctrl_q[CTRL_HEAT_BIT];
      hum_cfg_o.tres <= ctrl_q[CTRL_TRES_BIT];
      hum_cfg_o.hres <= ctrl_q[CTRL_HRES_LSB +: 2];
    end
  end

  // System tick from the auxiliary rate
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tick_cnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= aux_en && (tick_cnt_q == TW'(TICK_AUX - 1));
      if (aux_en) begin
        tick_cnt_q <= (tick_cnt_q == TW'(TICK_AUX - 1)) ? '0 :
                      tick_cnt_q + 1'b1;
      end
    end
  end

  // Watchdog: cleared on every tick, bites at the timeout
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wdog_cnt_q <= '0;
      wdog_bite_o <= 1'b0;
    end else begin
      wdog_bite_o <= 1'b0;
      if (tick_q) begin
        wdog_cnt_q <= '0;
      end else if (aux_en) begin
        if (wdog_cnt_q == WW'(WDOG_AUX - 1)) begin
          wdog_bite_o <= 1'b1;
          wdog_cnt_q <= '0;
        end else begin
          wdog_cnt_q <= wdog_cnt_q + 1'b1;
        end
      end
    end
  end

  // Interval counters; zero means a reading is due. A waking tick is
  // counted in its wake cycle, so that cycle still sees the old count.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pm_cnt_q <= '0;
      hum_cnt_q <= '0;
    end else if ((tick_q && !(st_q == ST_SLEEP && run)) ||
                 st_q == ST_WAKE) begin
      pm_cnt_q <= (pm_cnt_q == PMW'(PM_TICKS - 1)) ? '0 :
                  pm_cnt_q + 1'b1;
      hum_cnt_q <= (hum_cnt_q == HW'(HUM_TICKS - 1)) ? '0 :
                   hum_cnt_q + 1'b1;
    end
  end

  // Main sequencer
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_q <= ST_SLEEP;
    end else begin
      case (st_q)
        ST_SLEEP: begin
          if (tick_q && run) begin
            st_q <= ST_WAKE;
          end else if (hum_new_q && !pm_mode) begin
            st_q <= ST_SHOW;
          end
        end
        ST_WAKE: begin
          if (pm_mode && pm_cnt_q == '0) begin
            st_q <= ST_REF;
          end else begin
            st_q <= ST_SLEEP;
          end
        end
        ST_REF: begin
          if (ph_wrap && ref_got_q) begin
            st_q <= ST_RAMP;
          end
        end
        ST_RAMP: begin
          if (aux_en && ramp_cnt_q == RW'(RAMP_AUX - 1)) begin
            st_q <= ST_SAMP;
          end
        end
        ST_SAMP: begin
          if (ph_wrap && n_q == 6'(PM_SAMPLES)) begin
            st_q <= ST_FANOFF;
          end
        end
        ST_FANOFF: st_q <= ST_CALC;
        ST_CALC: st_q <= ST_SHOW;
        ST_SHOW: st_q <= ST_SLEEP;
        default: st_q <= ST_SLEEP;
      endcase
    end
  end

  // Low-power flag follows the sleep state
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lowpower_o <= 1'b0;
    end else begin
      lowpower_o <= (st_q == ST_SLEEP) && !(tick_q && run) &&
                    !(hum_new_q && !pm_mode);
    end
  end

  // Fan: on only from ramp through sampling, high means on
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fan_o <= 1'b0;
    end else if (st_q == ST_REF && ph_wrap && ref_got_q) begin
      fan_o <= 1'b1;
    end else if (st_q != ST_RAMP && st_q != ST_SAMP) begin
      fan_o <= 1'b0;
    end else if (st_q == ST_SAMP && ph_wrap && n_q == 6'(PM_SAMPLES)) begin
      fan_o <= 1'b0;
    end
  end

  // Fan ramp timer
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ramp_cnt_q <= '0;
    end else if (st_q != ST_RAMP) begin
      ramp_cnt_q <= '0;
    end else if (aux_en) begin
      ramp_cnt_q <= ramp_cnt_q + 1'b1;
    end
  end

  // Sensor pulse timer and ADC trigger
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ph_q <= '0;
      sensor_pulse_o <= 1'b0;
      adc_start_o <= 1'b0;
    end else if (!sampling) begin
      ph_q <= '0;
      sensor_pulse_o <= 1'b0;
      adc_start_o <= 1'b0;
    end else begin
      if (main_en) begin
        ph_q <= ph_wrap ? '0 : ph_q + 1'b1;
      end
      sensor_pulse_o <= (ph_q < PW'(PULSE_W_CYC));
      adc_start_o <= main_en && (ph_q == PW'(ADC_AT_CYC));
    end
  end

  // Reference sample and running sum
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ref_q <= '0;
      ref_got_q <= 1'b0;
      acc_q <= '0;
      n_q <= '0;
    end else if (st_q == ST_WAKE) begin
      ref_got_q <= 1'b0;
      acc_q <= '0;
      n_q <= '0;
    end else if (adc_done_i && st_q == ST_REF && !ref_got_q) begin
      ref_q <= adc_data_i;
      ref_got_q <= 1'b1;
    end else if (adc_done_i && st_q == ST_SAMP &&
                 n_q != 6'(PM_SAMPLES)) begin
      acc_q <= acc_q + ACC_W'(adc_data_i);
      n_q <= n_q + 1'b1;
    end
  end

  // Result: mean less reference, then threshold flags
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pm_q <= '0;
      pm_low_q <= 1'b0;
      pm_high_q <= 1'b0;
    end else if (st_q == ST_CALC) begin
      pm_q <= (mean > ref_q) ? mean - ref_q : '0;
      pm_low_q <= (mean <= ref_q) || (mean - ref_q < LOW_THR);
      pm_high_q <= (mean > ref_q) && (mean - ref_q > HIGH_THR);
    end
  end

  // Humidity: start on wake, read on ready, note fresh result
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hum_start_o <= 1'b0;
      hum_pend_q <= 1'b0;
      i2c_start_o <= 1'b0;
      i2c_busy_q <= 1'b0;
      hum_new_q <= 1'b0;
      ht_q <= '0;
    end else begin
      hum_start_o <= 1'b0;
      i2c_start_o <= 1'b0;
      if (st_q == ST_WAKE && hum_cnt_q == '0 && !hum_pend_q) begin
        hum_start_o <= 1'b1;
        hum_pend_q <= 1'b1;
      end
      if (hum_pend_q && hum_ready_i && !i2c_busy_q && !i2c_start_o) begin
        i2c_start_o <= 1'b1;
        i2c_busy_q <= 1'b1;
      end
      if (st_q == ST_SHOW) begin
        hum_new_q <= 1'b0;
      end
      if (i2c_busy_q && i2c_done_i) begin
        i2c_busy_q <= 1'b0;
        if (i2c_ok_i) begin
          ht_q <= i2c_data_i;
          hum_pend_q <= 1'b0;
          hum_new_q <= 1'b1;
        end
      end
    end
  end

  // Display: calibration banner, then result or range banner
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      disp_o <= '0;
    end else begin
      disp_o.upd <= 1'b0;
      if (st_q == ST_WAKE && pm_mode && pm_cnt_q == '0) begin
        disp_o <= '{upd: 1'b1, mask: MASK_3, chars: BAN_CAL};
      end else if (st_q == ST_SHOW) begin
        if (pm_mode && pm_low_q) begin
          disp_o <= '{upd: 1'b1, mask: MASK_3, chars: BAN_LOW};
        end else if (pm_mode && pm_high_q) begin
          disp_o <= '{upd: 1'b1, mask: MASK_4, chars: BAN_HIGH};
        end else if (aqs_glyph_ok(dig_chars[7:0])) begin
          disp_o <= '{upd: 1'b1, mask: MASK_4, chars: dig_chars};
        end
      end
    end
  end

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_ref_done;
    (st_q == ST_REF) ##1 (st_q == ST_RAMP);
  endsequence

  sequence s_samp_done;
    (st_q == ST_SAMP) ##1 (st_q == ST_FANOFF);
  endsequence

  AST_WDOG_KICK: assert property (tick_q |=> wdog_cnt_q == '0)
    else $error("watchdog not serviced on tick");

  AST_WDOG_BITE: assert property (
    (aux_en && !tick_q && wdog_cnt_q == WW'(WDOG_AUX - 1)) |=> wdog_bite_o)
    else $error("watchdog did not bite at timeout");

  AST_TICK_WAKE: assert property (
    (st_q == ST_SLEEP && tick_q && run) |=> (st_q == ST_WAKE))
    else $error("tick did not wake the sequencer");

  AST_REF_FAN_OFF: assert property ((st_q == ST_REF) |-> !fan_o)
    else $error("fan on during reference sample");

  AST_CAL_SHOWN: assert property (
    (st_q == ST_REF && $past(st_q) == ST_REF) |-> disp_o.chars == BAN_CAL)
    else $error("calibration banner missing");

  AST_FAN_ORDER: assert property (s_ref_done |-> fan_o)
    else $error("fan not on after reference");

  AST_N_SAMPLES: assert property (
    s_samp_done |-> n_q == 6'(PM_SAMPLES) && !fan_o ##2 st_q == ST_SHOW)
    else $error("sample count or order wrong");

  AST_ADC_IN_PULSE: assert property (adc_start_o |-> sensor_pulse_o)
    else $error("ADC trigger outside sensor pulse");

  AST_LOW_BANNER: assert property (
    (st_q == ST_SHOW && pm_mode && pm_low_q) |=> disp_o.chars == BAN_LOW)
    else $error("LOW banner missing");

  AST_HIGH_BANNER: assert property (
    (st_q == ST_SHOW && pm_mode && !pm_low_q && pm_high_q)
    |=> disp_o.chars == BAN_HIGH)
    else $error("HIGH banner missing");

  AST_SHOW_SLEEP: assert property (
    (st_q == ST_SHOW) |=> st_q == ST_SLEEP)
    else $error("no return to sleep after display");

  AST_SLEEP_LOWPOWER: assert property (
    (st_q == ST_SLEEP && !(tick_q && run) && !(hum_new_q && !pm_mode))
    |=> lowpower_o)
    else $error("idle sleep without low power");

  AST_I2C_READ: assert property (
    (hum_pend_q && hum_ready_i && !i2c_busy_q && !i2c_start_o)
    |=> i2c_start_o ##1 i2c_busy_q)
    else $error("ready did not start result read");

endmodule

// [verification/aqs_partner.sv]
`timescale 1ns/1ps
// Far side: dust sensor converter and humidity sensor on its serial link
module aqs_partner
  import aqs_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic fan_i,
  input wire logic adc_start_i,
  input wire logic hum_start_i,
  input wire logic i2c_start_i,
  output logic adc_done_o,
  output logic [ADC_W-1:0] adc_data_o,
  output logic hum_ready_o,
  output logic i2c_done_o,
  output logic i2c_ok_o,
  output logic [31:0] i2c_data_o
);
  int adc_cnt; // Cycles until a sample lands
  int hum_cnt; // Cycles until a result is ready
  int rd_cnt; // Cycles until a read ends
  logic fail_q; // First read is refused

  // Sample depends on the fan; idle data keeps toggling
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      adc_cnt <= 0;
      adc_done_o <= 1'b0;
      adc_data_o <= 12'h000;
    end else begin
      adc_done_o <= (adc_cnt == 1);
      if (adc_cnt == 1) adc_data_o <= fan_i ? 12'h800 : 12'h100;
      else adc_data_o <= ~adc_data_o;
      if (adc_start_i) adc_cnt <= 4;
      else if (adc_cnt > 0) adc_cnt <= adc_cnt - 1;
    end
  end

  // Humidity sensor: ready after a while, read answered slowly
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hum_cnt <= 0;
      rd_cnt <= 0;
      fail_q <= 1'b1;
      hum_ready_o <= 1'b0;
      i2c_done_o <= 1'b0;
      i2c_ok_o <= 1'b0;
      i2c_data_o <= 32'h0;
    end else begin
      i2c_done_o <= (rd_cnt == 1);
      i2c_ok_o <= (rd_cnt == 1) && !fail_q;
      if (rd_cnt == 1) i2c_data_o <= 32'h80008000;
      else i2c_data_o <= ~i2c_data_o;
      if (hum_cnt == 1) hum_ready_o <= 1'b1;
      else if (rd_cnt == 1) hum_ready_o <= 1'b0;
      if (rd_cnt == 1) fail_q <= 1'b0;
      // A refused read is followed by a fresh ready
      if (hum_start_i || (rd_cnt == 1 && fail_q)) hum_cnt <= 200;
      else if (hum_cnt > 0) hum_cnt <= hum_cnt - 1;
      if (i2c_start_i) rd_cnt <= 30;
      else if (rd_cnt > 0) rd_cnt <= rd_cnt - 1;
    end
  end
endmodule

// [verification/air_quality_measure_sequencer_tb_top.sv]
`timescale 1ns/1ps
module air_quality_measure_sequencer_tb_top;
  import aqs_pkg::*;
  logic clk_i = 1'b0, rstn_i = 1'b0, we_i = 1'b0, re_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [31:0] wdata_i = 32'h0, rdata_o, i2c_data_i, d;
  logic adc_done_i, hum_ready_i, i2c_done_i, i2c_ok_i, fan_o;
  logic sensor_pulse_o, adc_start_o, hum_start_o, i2c_start_o;
  logic lowpower_o, wdog_bite_o, fan_seen = 1'b0;
  logic [ADC_W-1:0] adc_data_i;
  aqs_hum_cfg_s hum_cfg_o;
  aqs_disp_s disp_o;
  int n_errors = 0, comparisons = 0, n_i2c = 0, n_bite = 0;

  always #5 clk_i = ~clk_i; // 100 MHz

  aqs_sequencer #(.WDOG_AUX(70), .TICK_AUX(20), .RAMP_AUX(5),
    .SAMP_PER(2600), .AUX_DIVIDE(4)) i_dut (.clk_i(clk_i),
    .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i),
    .re_i(re_i), .rdata_o(rdata_o), .adc_done_i(adc_done_i),
    .adc_data_i(adc_data_i), .hum_ready_i(hum_ready_i),
    .i2c_done_i(i2c_done_i), .i2c_ok_i(i2c_ok_i), .i2c_data_i(i2c_data_i),
    .fan_o(fan_o), .sensor_pulse_o(sensor_pulse_o),
    .adc_start_o(adc_start_o), .hum_start_o(hum_start_o),
    .i2c_start_o(i2c_start_o), .hum_cfg_o(hum_cfg_o), .disp_o(disp_o),
    .lowpower_o(lowpower_o), .wdog_bite_o(wdog_bite_o));

  aqs_partner i_far (.clk_i(clk_i), .rstn_i(rstn_i), .fan_i(fan_o),
    .adc_start_i(adc_start_o), .hum_start_i(hum_start_o),
    .i2c_start_i(i2c_start_o), .adc_done_o(adc_done_i),
    .adc_data_o(adc_data_i), .hum_ready_o(hum_ready_i),
    .i2c_done_o(i2c_done_i), .i2c_ok_o(i2c_ok_i), .i2c_data_o(i2c_data_i));

  // Event counters seen at the ports
  always @(posedge clk_i) begin
    if (i2c_start_o === 1'b1) n_i2c++;
    if (wdog_bite_o === 1'b1) n_bite++;
    if (fan_o === 1'b1) fan_seen = 1'b1;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Register write: one strobe cycle
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= v;
    we_i <= 1'b1;
    @(posedge clk_i);
    we_i <= 1'b0;
  endtask

  // Register read: data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk_i);
    addr_i <= a;
    re_i <= 1'b1;
    @(posedge clk_i);
    re_i <= 1'b0;
    #1 v = rdata_o;
  endtask

  function automatic logic hit(input int k);
    case (k)
      0: hit = disp_o.upd;
      1: hit = adc_start_o;
      2: hit = fan_o;
      default: hit = hum_start_o;
    endcase
  endfunction

  // Bounded wait for one of the events above
  task automatic wt(input int k, input int lim);
    int i;
    i = 0;
    do begin
      @(posedge clk_i);
      #1 i++;
    end while (hit(k) !== 1'b1 && i < lim);
    if (i >= lim) chk(32'h0, 32'h1);
  endtask

  task automatic stop_test;
    if (n_errors == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Hang guard, well beyond the expected run
  initial begin
    repeat (100000) @(posedge clk_i);
    chk(32'h0, 32'h2);
    stop_test();
  end

  initial begin
    repeat (6) @(posedge clk_i);
    rstn_i <= 1'b1;
    rd(REG_CTRL, d);
    chk(d, 32'(CTRL_RST));
    rd(4'h2, d);
    chk(d, 32'h0);
    wr(REG_CTRL, 32'h6f);
    @(posedge clk_i);
    #1 chk(32'(hum_cfg_o), 32'he);
    // Particulate run: reference with fan off, then ramp and samples
    wt(0, 400);
    chk(disp_o.chars, BAN_CAL);
    chk(32'(fan_o), 32'h0);
    wt(1, 40000);
    chk(32'({sensor_pulse_o, fan_o}), 32'h2);
    wt(2, 40000);
    rd(REG_STATUS, d);
    chk(d & 32'h17, 32'h12);
    wt(1, 40000);
    chk(32'({sensor_pulse_o, fan_o}), 32'h3);
    // Second reset mid-sample, then temperature mode
    @(posedge clk_i);
    rstn_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    chk(32'(fan_o), 32'h0);
    rstn_i <= 1'b1;
    fan_seen = 1'b0;
    n_i2c = 0;
    wr(REG_CTRL, 32'h40);
    wt(3, 400);
    repeat (4) @(posedge clk_i);
    #1 chk(32'(lowpower_o), 32'h1);
    wt(0, 3000);
    chk(disp_o.chars, 32'h30303432);
    chk(n_i2c, 32'h2);
    repeat (4) @(posedge clk_i);
    #1 chk(32'(lowpower_o), 32'h1);
    chk(32'(fan_seen), 32'h0);
    chk(n_bite, 32'h0);
    stop_test();
  end
endmodule
